// ===== lnb_regs_pkg.sv
/*
  Constants and types shared by the supply-regulator register logic.
  Assumes a 125 MHz system clock and a two-wire serial bus as the only register port.
*/
package lnb_regs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int CLK_FREQ_MHZ = 125;
  localparam int OC_DISABLE_TIME_US = 45000;
  localparam int OC_DISABLE_CYCLES = OC_DISABLE_TIME_US * CLK_FREQ_MHZ;
  localparam int OC_CNT_W = 23;

  // Arbitrary bus address, chosen freely for this design.
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h08;

  ////////////////////////////////////////////////////////////////////////////
  localparam int CTRL_W = 4;
  localparam int CTRL_LEVEL_LSB = 0;
  localparam int CTRL_LEVEL_MSB = 2;
  localparam int CTRL_ON_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  localparam int ST_OFF = 0;
  localparam int ST_PUMP = 1;
  localparam int ST_OC = 2;
  localparam int ST_TRIM = 3;
  localparam int ST_RANGE = 4;
  localparam int ST_TEMP = 6;
  localparam int ST_SUPPLY = 7;

  ////////////////////////////////////////////////////////////////////////////
  localparam int SN_SCL = 0;
  localparam int SN_SDA = 1;
  localparam int SN_SUPPLY_LOW = 2;
  localparam int SN_SUPPLY_OK = 3;
  localparam int SN_OVERCURRENT = 4;
  localparam int SN_OVERTEMP = 5;
  localparam int SN_TEMP_OK = 6;
  localparam int SN_PUMP_GOOD = 7;
  localparam int SN_RANGE_WIDE = 8;
  localparam int SN_RANGE_NARROW = 9;
  localparam int SN_TRIM = 10;
  localparam int SN_W = 11;

  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int MV_W = 15;

  // Output targets in millivolts, indexed by the level code.
  localparam logic [7:0][14:0] LEVEL_TARGET_MV = {
    15'h4e20, 15'h4cd3, 15'h4a38, 15'h48eb,
    15'h3d33, 15'h37fd, 15'h3563, 15'h3415
  };

  typedef enum logic [2:0] {
    BUS_IDLE = 3'h0,
    BUS_ADDR = 3'h1,
    BUS_ADDR_ACK = 3'h3,
    BUS_WR_DATA = 3'h2,
    BUS_WR_ACK = 3'h6,
    BUS_RD_DATA = 3'h7,
    BUS_RD_ACK = 3'h5,
    BUS_WAIT = 3'h4
  } bus_state_type;

endpackage : lnb_regs_pkg

// ===== sense_sync.sv
/*
  Two-stage synchroniser for a vector of asynchronous level inputs.
  Assumes each bit is a slow level; no bit relation is kept across the vector.
*/
`timescale 1ns/100ps
module sense_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [W-1:0] raw_i,
  input wire logic [W-1:0] rst_val_i,
  output logic [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] first;
    logic [W-1:0] second;
  } sync_state_type;

  sync_state_type q;
  sync_state_type d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d.first = raw_i ^ rst_val_i;
    d.second = q.first;
  end

  // The flops hold each bit relative to its idle level, so the constant reset presents the idle level.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_o = q.second ^ rst_val_i;

endmodule : sense_sync

// ===== lnb_control_status_regs.sv
/*
  Control and status registers of the output supply regulator, reached over
  the two-wire serial bus: one write register, one read register, an
  open-drain attention request line.
  Assumes analog comparators deliver the sensed conditions as levels and the
  bus master keeps to standard two-wire signalling at a much slower rate.
*/
`timescale 1ns/100ps
module lnb_control_status_regs #(
  parameter logic [6:0] DEV_ADDR = lnb_regs_pkg::DEV_ADDR_DEFAULT,
  parameter int unsigned OC_DISABLE_CYCLES = lnb_regs_pkg::OC_DISABLE_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  output logic attn_o,
  output logic attn_oe_n_o,
  input wire logic supply_low_i,
  input wire logic supply_ok_i,
  input wire logic overcurrent_i,
  input wire logic overtemp_i,
  input wire logic temp_ok_i,
  input wire logic pump_good_i,
  input wire logic range_wide_i,
  input wire logic range_narrow_i,
  input wire logic trim_lock_i,
  output logic [2:0] level_code_o,
  output logic [14:0] level_target_mv_o,
  output logic output_on_o
);

  typedef struct packed {
    lnb_regs_pkg::bus_state_type st;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic rw;
    logic acked;
    logic scl_prev;
    logic sda_prev;
    logic sda_oe_n;
    logic [lnb_regs_pkg::CTRL_W-1:0] ctrl;
    logic off_flag;
    logic pump_flag;
    logic oc_flag;
    logic trim_flag;
    logic range_flag;
    logic temp_flag;
    logic supply_flag;
    logic attn_oe_n;
    logic [lnb_regs_pkg::OC_CNT_W-1:0] oc_cnt;
    logic out_on;
    logic [lnb_regs_pkg::MV_W-1:0] target_mv;
  } state_type;

  localparam state_type RESET_STATE = '{
    st: lnb_regs_pkg::BUS_IDLE,
    scl_prev: 1'b1,
    sda_prev: 1'b1,
    sda_oe_n: 1'b1,
    ctrl: lnb_regs_pkg::CTRL_RESET,
    off_flag: 1'b1,
    attn_oe_n: 1'b1,
    target_mv: lnb_regs_pkg::LEVEL_TARGET_MV[0],
    default: '0
  };

  localparam logic [lnb_regs_pkg::OC_CNT_W-1:0] OC_LIMIT =
    lnb_regs_pkg::OC_CNT_W'(OC_DISABLE_CYCLES);

  // Bus lines idle high; starting the synchroniser there avoids a false bus edge after reset.
  localparam logic [lnb_regs_pkg::SN_W-1:0] SN_IDLE = (lnb_regs_pkg::SN_W'(1) << lnb_regs_pkg::SN_SCL)
    | (lnb_regs_pkg::SN_W'(1) << lnb_regs_pkg::SN_SDA);

  state_type q;
  state_type d;

  logic [lnb_regs_pkg::SN_W-1:0] raw;
  logic [lnb_regs_pkg::SN_W-1:0] sn;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic status_acked;
  logic enable_write;
  logic oc_event;
  logic any_fault;
  logic off_set;
  logic [7:0] status_now;

  // Composes the read register from the flags.
  function automatic logic [7:0] status_byte(input state_type s);
    logic [7:0] b;
    b = 8'h00;
    b[lnb_regs_pkg::ST_OFF] = s.off_flag;
    b[lnb_regs_pkg::ST_PUMP] = s.pump_flag;
    b[lnb_regs_pkg::ST_OC] = s.oc_flag;
    b[lnb_regs_pkg::ST_TRIM] = s.trim_flag;
    b[lnb_regs_pkg::ST_RANGE] = s.range_flag;
    b[lnb_regs_pkg::ST_TEMP] = s.temp_flag;
    b[lnb_regs_pkg::ST_SUPPLY] = s.supply_flag;
    return b;
  endfunction : status_byte

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    raw = '0;
    raw[lnb_regs_pkg::SN_SCL] = scl_i;
    raw[lnb_regs_pkg::SN_SDA] = sda_i;
    raw[lnb_regs_pkg::SN_SUPPLY_LOW] = supply_low_i;
    raw[lnb_regs_pkg::SN_SUPPLY_OK] = supply_ok_i;
    raw[lnb_regs_pkg::SN_OVERCURRENT] = overcurrent_i;
    raw[lnb_regs_pkg::SN_OVERTEMP] = overtemp_i;
    raw[lnb_regs_pkg::SN_TEMP_OK] = temp_ok_i;
    raw[lnb_regs_pkg::SN_PUMP_GOOD] = pump_good_i;
    raw[lnb_regs_pkg::SN_RANGE_WIDE] = range_wide_i;
    raw[lnb_regs_pkg::SN_RANGE_NARROW] = range_narrow_i;
    raw[lnb_regs_pkg::SN_TRIM] = trim_lock_i;
  end

  sense_sync #(
    .W(lnb_regs_pkg::SN_W)
  ) u_sense_sync (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .raw_i(raw),
    .rst_val_i(SN_IDLE),
    .sync_o(sn)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    scl_rise = sn[lnb_regs_pkg::SN_SCL] & ~q.scl_prev;
    scl_fall = ~sn[lnb_regs_pkg::SN_SCL] & q.scl_prev;
    bus_start = sn[lnb_regs_pkg::SN_SCL] & q.sda_prev & ~sn[lnb_regs_pkg::SN_SDA];
    bus_stop = sn[lnb_regs_pkg::SN_SCL] & ~q.sda_prev & sn[lnb_regs_pkg::SN_SDA];
    status_acked = (q.st == lnb_regs_pkg::BUS_RD_ACK) & scl_rise & ~sn[lnb_regs_pkg::SN_SDA];
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    enable_write = 1'b0;
    status_now = status_byte(q);
    d.scl_prev = sn[lnb_regs_pkg::SN_SCL];
    d.sda_prev = sn[lnb_regs_pkg::SN_SDA];

    if (bus_start) begin
      d.st = lnb_regs_pkg::BUS_ADDR;
      d.bit_cnt = '0;
      d.sda_oe_n = 1'b1;
    end else if (bus_stop) begin
      d.st = lnb_regs_pkg::BUS_IDLE;
      d.sda_oe_n = 1'b1;
    end else begin
      case (q.st)
        lnb_regs_pkg::BUS_ADDR: begin
          if (scl_rise) begin
            d.shift = {q.shift[6:0], sn[lnb_regs_pkg::SN_SDA]};
            d.bit_cnt = q.bit_cnt + 4'h1;
          end else if (scl_fall && q.bit_cnt == lnb_regs_pkg::BYTE_BITS) begin
            d.bit_cnt = '0;
            if (q.shift[7:1] == DEV_ADDR) begin
              d.sda_oe_n = 1'b0;
              d.rw = q.shift[0];
              d.st = lnb_regs_pkg::BUS_ADDR_ACK;
            end else begin
              d.st = lnb_regs_pkg::BUS_WAIT;
            end
          end
        end
        lnb_regs_pkg::BUS_ADDR_ACK: begin
          if (scl_fall) begin
            if (q.rw) begin
              d.shift = status_now << 1;
              d.sda_oe_n = status_now[7];
              d.bit_cnt = 4'h1;
              d.st = lnb_regs_pkg::BUS_RD_DATA;
            end else begin
              d.sda_oe_n = 1'b1;
              d.bit_cnt = '0;
              d.st = lnb_regs_pkg::BUS_WR_DATA;
            end
          end
        end
        lnb_regs_pkg::BUS_WR_DATA: begin
          if (scl_rise) begin
            d.shift = {q.shift[6:0], sn[lnb_regs_pkg::SN_SDA]};
            d.bit_cnt = q.bit_cnt + 4'h1;
          end else if (scl_fall && q.bit_cnt == lnb_regs_pkg::BYTE_BITS) begin
            d.sda_oe_n = 1'b0;
            d.ctrl = q.shift[lnb_regs_pkg::CTRL_W-1:0];
            enable_write = q.shift[lnb_regs_pkg::CTRL_ON_BIT];
            d.st = lnb_regs_pkg::BUS_WR_ACK;
          end
        end
        lnb_regs_pkg::BUS_WR_ACK: begin
          if (scl_fall) begin
            d.sda_oe_n = 1'b1;
            d.bit_cnt = '0;
            d.st = lnb_regs_pkg::BUS_WR_DATA;
          end
        end
        lnb_regs_pkg::BUS_RD_DATA: begin
          if (scl_fall) begin
            if (q.bit_cnt == lnb_regs_pkg::BYTE_BITS) begin
              d.sda_oe_n = 1'b1;
              d.st = lnb_regs_pkg::BUS_RD_ACK;
            end else begin
              d.sda_oe_n = q.shift[7];
              d.shift = q.shift << 1;
              d.bit_cnt = q.bit_cnt + 4'h1;
            end
          end
        end
        lnb_regs_pkg::BUS_RD_ACK: begin
          if (scl_rise) begin
            d.acked = ~sn[lnb_regs_pkg::SN_SDA];
          end else if (scl_fall) begin
            if (q.acked) begin
              d.shift = status_now << 1;
              d.sda_oe_n = status_now[7];
              d.bit_cnt = 4'h1;
              d.st = lnb_regs_pkg::BUS_RD_DATA;
            end else begin
              d.st = lnb_regs_pkg::BUS_WAIT;
            end
          end
        end
        lnb_regs_pkg::BUS_IDLE, lnb_regs_pkg::BUS_WAIT: begin
          d.sda_oe_n = 1'b1;
        end
        default: begin
          d.st = lnb_regs_pkg::BUS_IDLE;
          d.sda_oe_n = 1'b1;
        end
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Overcurrent disable timer
    if (!sn[lnb_regs_pkg::SN_OVERCURRENT]) begin
      d.oc_cnt = '0;
    end else if (q.oc_cnt != OC_LIMIT) begin
      d.oc_cnt = q.oc_cnt + lnb_regs_pkg::OC_CNT_W'(1);
    end
    oc_event = sn[lnb_regs_pkg::SN_OVERCURRENT] & (q.oc_cnt == OC_LIMIT);

    d.supply_flag = sn[lnb_regs_pkg::SN_SUPPLY_LOW] | (q.supply_flag & ~(status_acked
      & sn[lnb_regs_pkg::SN_SUPPLY_OK]));
    d.oc_flag = oc_event | (q.oc_flag & ~(status_acked & ~sn[lnb_regs_pkg::SN_OVERCURRENT]));
    d.temp_flag = sn[lnb_regs_pkg::SN_OVERTEMP] | (q.temp_flag & ~(status_acked
      & sn[lnb_regs_pkg::SN_TEMP_OK]));

    d.pump_flag = sn[lnb_regs_pkg::SN_PUMP_GOOD];
    d.trim_flag = q.trim_flag | sn[lnb_regs_pkg::SN_TRIM];

    if (q.out_on && sn[lnb_regs_pkg::SN_RANGE_WIDE]) begin
      d.range_flag = 1'b1;
    end else if (q.out_on && sn[lnb_regs_pkg::SN_RANGE_NARROW]) begin
      d.range_flag = 1'b0;
    end

    any_fault = d.supply_flag | d.oc_flag | d.temp_flag | ~sn[lnb_regs_pkg::SN_PUMP_GOOD];
    off_set = any_fault | ~d.ctrl[lnb_regs_pkg::CTRL_ON_BIT];
    d.off_flag = off_set | (q.off_flag & ~enable_write);
    d.out_on = ~d.off_flag;

    if ((sn[lnb_regs_pkg::SN_SUPPLY_LOW] & ~q.supply_flag) | (oc_event & ~q.oc_flag)
        | (sn[lnb_regs_pkg::SN_OVERTEMP] & ~q.temp_flag)) begin
      d.attn_oe_n = 1'b0;
    end else if (status_acked) begin
      d.attn_oe_n = 1'b1;
    end

    d.target_mv = lnb_regs_pkg::LEVEL_TARGET_MV[d.ctrl[lnb_regs_pkg::CTRL_LEVEL_MSB:lnb_regs_pkg::CTRL_LEVEL_LSB]];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control reset to zero
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= RESET_STATE;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign sda_o = 1'b0;
  assign sda_oe_n_o = q.sda_oe_n;
  assign attn_o = 1'b0;
  assign attn_oe_n_o = q.attn_oe_n;
  assign level_code_o = q.ctrl[lnb_regs_pkg::CTRL_LEVEL_MSB:lnb_regs_pkg::CTRL_LEVEL_LSB];
  assign level_target_mv_o = q.target_mv;
  assign output_on_o = q.out_on;

endmodule : lnb_control_status_regs

// ===== lnb_regs_assertions.sv
/*
  Concurrent checks on the regulator register block, bound to its top module.
  Assumes the bench holds fault inputs steady for several cycles at a time.
*/
`timescale 1ns/100ps
module lnb_regs_assertions #(
  parameter int unsigned OC_DISABLE_CYCLES = lnb_regs_pkg::OC_DISABLE_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic attn_o,
  input wire logic attn_oe_n_o,
  input wire logic supply_low_i,
  input wire logic overcurrent_i,
  input wire logic overtemp_i,
  input wire logic pump_good_i,
  input wire logic [2:0] level_code_o,
  input wire logic [14:0] level_target_mv_o,
  input wire logic output_on_o
);
  int unsigned oc_run_q;
  logic [3:0] ev_age_q;

  // Counts the current overcurrent run and the age of the last event input.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      oc_run_q <= 0;
      ev_age_q <= 4'hf;
    end else begin
      oc_run_q <= overcurrent_i ? oc_run_q + 1 : 0;
      if (supply_low_i | overcurrent_i | overtemp_i) begin
        ev_age_q <= 4'h0;
      end else if (ev_age_q != 4'hf) begin
        ev_age_q <= ev_age_q + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_held(logic f);
    f [*6];
  endsequence

  sequence s_code_steady;
    $stable(level_code_o) ##1 $stable(level_code_o);
  endsequence

  a_target_follows_code: assert property (s_code_steady |->
    level_target_mv_o == lnb_regs_pkg::LEVEL_TARGET_MV[level_code_o]) else $error("target mismatch");
  a_temp_disables: assert property (s_held(overtemp_i) |=> !output_on_o)
    else $error("output on while hot");
  a_pump_disables: assert property (s_held(!pump_good_i) |=> !output_on_o)
    else $error("output on with pump bad");
  a_supply_disables: assert property (s_held(supply_low_i) |=> !output_on_o)
    else $error("output on with supply low");
  a_attn_needs_event: assert property ($fell(attn_oe_n_o) |-> ev_age_q < 4'h8)
    else $error("attention without event");
  a_attn_oc_time: assert property ($fell(attn_oe_n_o) && !supply_low_i && !overtemp_i
    |-> oc_run_q >= OC_DISABLE_CYCLES) else $error("overcurrent flagged early");
  a_enable_fault_free: assert property ($rose(output_on_o)
    |-> !overtemp_i && !supply_low_i && pump_good_i) else $error("enabled under fault");
  a_code_bus_only: assert property ($changed(level_code_o) |-> !scl_i)
    else $error("code changed off bus");
  a_drive_scl_low: assert property ($changed(sda_oe_n_o) |-> !scl_i)
    else $error("data drive changed with clock high");
  a_open_drain_low: assert property (attn_o == 1'b0 && sda_o == 1'b0)
    else $error("open drain value not low");
endmodule : lnb_regs_assertions

bind lnb_control_status_regs lnb_regs_assertions #(.OC_DISABLE_CYCLES(OC_DISABLE_CYCLES)) u_chk (
  .sys_clk_i, .sys_rst_i, .scl_i, .sda_o, .sda_oe_n_o, .attn_o, .attn_oe_n_o, .supply_low_i,
  .overcurrent_i, .overtemp_i, .pump_good_i, .level_code_o, .level_target_mv_o, .output_on_o);

// ===== i2c_master_model.sv
/*
  Two-wire bus master model for the register port, slow bit timing.
  Assumes the bench resolves the open-drain data line and feeds it back.
*/
`timescale 1ns/100ps
module i2c_master_model (
  input wire logic sys_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic hc();
    repeat (8) @(posedge sys_clk_i);
  endtask : hc

  task automatic bit_io(input logic b, output logic r);
    repeat (2) @(posedge sys_clk_i);
    sda_o <= b;
    hc();
    scl_o <= 1'b1;
    hc();
    r = sda_i;
    scl_o <= 1'b0;
  endtask : bit_io

  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
  endtask : byte_io

  task automatic xfer(input logic [6:0] addr, input logic rd, input logic [7:0] wd,
                      input logic mack, output logic [7:0] rx, output logic aok);
    logic [7:0] tmp;
    logic ak;
    sda_o <= 1'b1;
    hc();
    scl_o <= 1'b1;
    hc();
    sda_o <= 1'b0;
    hc();
    scl_o <= 1'b0;
    byte_io({addr, rd}, tmp);
    bit_io(1'b1, ak);
    aok = ~ak;
    byte_io(rd ? 8'hff : {4'h0, wd[3:0]}, rx);
    bit_io(rd ? ~mack : 1'b1, ak);
    if (!rd) begin
      aok = aok & ~ak;
    end
    // After an acknowledge the device sends the next status byte; take it and refuse it before stopping.
    if (rd && mack) begin
      byte_io(8'hff, tmp);
      bit_io(1'b1, ak);
    end
    repeat (2) @(posedge sys_clk_i);
    sda_o <= 1'b0;
    hc();
    scl_o <= 1'b1;
    hc();
    sda_o <= 1'b1;
    hc();
  endtask : xfer
endmodule : i2c_master_model

// ===== tb_lnb_control_status_regs.sv
/*
  Self-checking bench for the regulator register block.
  Assumes a short overcurrent time set through the block's parameter.
*/
`timescale 1ns/100ps
module tb_lnb_control_status_regs;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic supply_low_i = 1'b0, supply_ok_i = 1'b1, overcurrent_i = 1'b0, overtemp_i = 1'b0;
  logic temp_ok_i = 1'b1, pump_good_i = 1'b1, range_wide_i = 1'b0, range_narrow_i = 1'b1;
  logic trim_lock_i = 1'b0;
  logic scl, sda_m, sda_o, sda_oe_n, attn_o, attn_oe_n, output_on, aok;
  logic [2:0] level_code;
  logic [14:0] target_mv;
  logic [7:0] rx;
  wire sda = sda_m & (sda_oe_n | sda_o);
  int n_errors = 0;
  int total_checks = 0;

  initial begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  lnb_control_status_regs #(.OC_DISABLE_CYCLES(20)) dut (.sys_clk_i, .sys_rst_i, .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .attn_o(attn_o), .attn_oe_n_o(attn_oe_n),
    .supply_low_i, .supply_ok_i, .overcurrent_i, .overtemp_i, .temp_ok_i, .pump_good_i,
    .range_wide_i, .range_narrow_i, .trim_lock_i, .level_code_o(level_code),
    .level_target_mv_o(target_mv), .output_on_o(output_on));

  i2c_master_model m (.sys_clk_i, .sda_i(sda), .scl_o(scl), .sda_o(sda_m));

  task automatic waitc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : waitc

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic rd(input logic mack, input logic [7:0] exp);
    m.xfer(lnb_regs_pkg::DEV_ADDR_DEFAULT, 1'b1, 8'h00, mack, rx, aok);
    chk({7'h00, aok, rx}, {8'h01, exp}, "status");
  endtask : rd

  task automatic wr(input logic [7:0] d);
    m.xfer(lnb_regs_pkg::DEV_ADDR_DEFAULT, 1'b0, d, 1'b1, rx, aok);
    chk(aok, 1'b1, "write ack");
  endtask : wr

  task automatic finish_test();
    if (n_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_levels();
    logic [14:0] mv [8] = '{15'h3415, 15'h3563, 15'h37fd, 15'h3d33, 15'h48eb, 15'h4a38, 15'h4cd3, 15'h4e20};
    chk({level_code, output_on, attn_oe_n, target_mv}, {5'h01, 15'h3415}, "reset");
    rd(1'b1, 8'h03);
    for (int c = 0; c < 8; c++) begin
      wr({5'h01, c[2:0]});
      chk({level_code, output_on}, {c[2:0], 1'b1}, "code");
      chk(target_mv, mv[c], "target");
    end
    wr(8'h05);
    chk(output_on, 1'b0, "off");
    rd(1'b1, 8'h03);
  endtask : t_levels

  task automatic t_faults();
    wr(8'h08);
    overtemp_i <= 1'b1;
    temp_ok_i <= 1'b0;
    waitc(10);
    chk({attn_oe_n, output_on}, 2'b00, "hot");
    overtemp_i <= 1'b0;
    temp_ok_i <= 1'b1;
    rd(1'b0, 8'h43);
    chk(attn_oe_n, 1'b0, "nack kept");
    rd(1'b1, 8'h43);
    chk(attn_oe_n, 1'b1, "ack release");
    rd(1'b1, 8'h03);
    wr(8'h08);
    rd(1'b1, 8'h02);
    overcurrent_i <= 1'b1;
    waitc(10);
    overcurrent_i <= 1'b0;
    waitc(10);
    chk(attn_oe_n, 1'b1, "short load");
    overcurrent_i <= 1'b1;
    waitc(40);
    chk({attn_oe_n, output_on}, 2'b00, "overload");
    overcurrent_i <= 1'b0;
    rd(1'b1, 8'h07);
    rd(1'b1, 8'h03);
    wr(8'h08);
    supply_low_i <= 1'b1;
    supply_ok_i <= 1'b0;
    waitc(10);
    chk({attn_oe_n, output_on}, 2'b00, "supply");
    supply_low_i <= 1'b0;
    rd(1'b1, 8'h83);
    rd(1'b1, 8'h83);
    supply_ok_i <= 1'b1;
    rd(1'b1, 8'h83);
    rd(1'b1, 8'h03);
  endtask : t_faults

  task automatic t_live();
    wr(8'h08);
    pump_good_i <= 1'b0;
    waitc(10);
    chk({attn_oe_n, output_on}, 2'b10, "pump");
    rd(1'b1, 8'h01);
    pump_good_i <= 1'b1;
    waitc(10);
    rd(1'b1, 8'h03);
    wr(8'h08);
    range_wide_i <= 1'b1;
    range_narrow_i <= 1'b0;
    waitc(10);
    chk(attn_oe_n, 1'b1, "range");
    rd(1'b1, 8'h12);
    range_wide_i <= 1'b0;
    range_narrow_i <= 1'b1;
    waitc(10);
    rd(1'b1, 8'h02);
    trim_lock_i <= 1'b1;
    waitc(10);
    trim_lock_i <= 1'b0;
    rd(1'b1, 8'h0a);
    rd(1'b1, 8'h0a);
    m.xfer(7'h09, 1'b1, 8'h00, 1'b1, rx, aok);
    chk(aok, 1'b0, "foreign address");
  endtask : t_live

  initial begin
    waitc(16);
    sys_rst_i <= 1'b0;
    waitc(8);
    t_levels();
    t_faults();
    t_live();
    finish_test();
  end

  initial begin
    waitc(60000);
    n_errors++;
    finish_test();
  end
endmodule : tb_lnb_control_status_regs
